// ---- hdl/rpap_parser.sv ----
// remote command parser with setup register slave
// What this block does
// - after start, data register bit set means that channel failed
// - start resets link state and status, no device specific setup
// - after trigger, command clear; nonzero data register means error
// - read codes 0x44..0x47 return one, two, four, eight bytes
// - write codes 0x64..0x67 carry one, two, four, eight bytes
// - descriptor table pointer readable after start; zero means unsupported
// - every command opens with a header choosing kind, address, length
// - header bits 7..6 01b is data access, bit 5 selects write
// - bit 4 picks macro body or stream data, only inside macros
// - bit 3 post-increments the pointer by the transfer size
// - bit 2 set means two address bytes follow, low first
// - bits 1..0 give one, two, four or eight bytes
// - multi-byte transfers touch successive byte addresses
// - one byte runs any of 64 stored command macros
// - header class 10b calls macro number in low six bits
// - commands carry crc-8 x^8+x^5+x^4+1; replies append a crc byte
// - a reply without data still sends one crc byte of zero
// - parser resets when the stream idles past the command timeout
`timescale 1ns/1ps
module rpap_parser (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // channel link state pins
  input wire logic [7:0] chan_link_ok,
  // serial byte stream in
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // serial byte stream out
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data
);

  typedef struct packed {
    rpap_pkg::rpap_state_t state;
    logic in_macro;
    logic [7:0] hdr;
    logic [9:0] mptr;
    logic [15:0] xaddr;
    logic [15:0] aptr;
    logic [3:0] cnt;
    logic [7:0] rxcrc;
    logic [7:0] txcrc;
    logic [7:0] txbyte;
    logic sent_any;
    logic [15:0] idle_cnt;
    logic crc_err;
    logic halted;
    logic [7:0] fail;
    logic [15:0] desc_ptr;
    logic [15:0] timeout;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] lk1;
    logic [7:0] lk2;
    logic [7:0] lk3;
    logic [7:0] lkq;
  } rpap_regs_t;

  localparam rpap_regs_t REGS_RST = '{state: rpap_pkg::ST_HDR, timeout: rpap_pkg::TIMEOUT_RST, default: '0};

  rpap_regs_t r_reg;
  rpap_regs_t r_next;
  logic from_mem;
  logic wait_rx;
  logic [7:0] in_b;
  logic mem_we;
  logic [9:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [15:0] mem_word;
  logic bus_take;
  logic bus_wr;
  logic [11:0] cmd_val;
  logic last_byte;

  // ==========================================================
  // remote memory
  rpap_ram u_ram (
    .mclk(mclk),
    .we(mem_we),
    .waddr(r_reg.xaddr[9:0]),
    .wdata(in_b),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .waddr_word(rpap_pkg::DESC_PTR_LOC),
    .rword(mem_word)
  );

  // ==========================================================
  // byte source selection
  always_comb begin
    from_mem = r_reg.in_macro && (r_reg.state == rpap_pkg::ST_HDR || r_reg.state == rpap_pkg::ST_ALO ||
               r_reg.state == rpap_pkg::ST_AHI ||
               (r_reg.state == rpap_pkg::ST_XFER && r_reg.hdr[rpap_pkg::HB_WRITE] && r_reg.hdr[rpap_pkg::HB_FROM_MACRO]));
    wait_rx = !r_reg.halted && !from_mem && (r_reg.state == rpap_pkg::ST_HDR || r_reg.state == rpap_pkg::ST_ALO ||
              r_reg.state == rpap_pkg::ST_AHI || r_reg.state == rpap_pkg::ST_CRCIN ||
              (r_reg.state == rpap_pkg::ST_XFER && r_reg.hdr[rpap_pkg::HB_WRITE]));
    mem_raddr = (r_reg.state == rpap_pkg::ST_XFER && !r_reg.hdr[rpap_pkg::HB_WRITE]) ? r_reg.xaddr[9:0] : r_reg.mptr;
    in_b = from_mem ? mem_rdata : rx_data;
    last_byte = r_reg.cnt == 4'h1;
    bus_take = (avs_read || avs_write) && !r_reg.ack;
    bus_wr = avs_write && r_reg.ack;
    cmd_val = avs_writedata[11:0];
  end

  // ==========================================================
  // next state
  always_comb begin
    r_next = r_reg;
    mem_we = 1'b0;
    r_next.lk1 = chan_link_ok;
    r_next.lk2 = r_reg.lk1;
    r_next.lk3 = r_reg.lk2;
    if (r_reg.lk2 == r_reg.lk3) begin
      r_next.lkq = r_reg.lk3;
    end
    if (wait_rx && rx_valid) begin
      r_next.rxcrc = rpap_pkg::rpap_crc8(r_reg.rxcrc, rx_data);
    end
    if (!wait_rx || rx_valid) begin
      r_next.idle_cnt = 16'h0000;
    end else if (r_reg.idle_cnt != r_reg.timeout) begin
      r_next.idle_cnt = 16'(r_reg.idle_cnt + 16'h0001);
    end
    case (r_reg.state)
      rpap_pkg::ST_HDR: begin
        if (from_mem) begin
          r_next.mptr = 10'(r_reg.mptr + 10'h001);
          if (in_b == 8'h00) begin
            r_next.state = rpap_pkg::ST_CRCIN;
          end
        end
        if (from_mem || (wait_rx && rx_valid)) begin
          if (in_b[7:6] == rpap_pkg::CLASS_DATA) begin
            r_next.hdr = in_b;
            r_next.cnt = 4'h1 << in_b[1:0];
            if (in_b[rpap_pkg::HB_ADDR_FIELD]) begin
              r_next.state = rpap_pkg::ST_ALO;
            end else begin
              r_next.xaddr = r_reg.aptr;
              r_next.state = rpap_pkg::ST_XFER;
            end
          end else if (in_b[7:6] == rpap_pkg::CLASS_MACRO && !from_mem) begin
            r_next.in_macro = 1'b1;
            r_next.mptr = {1'b0, in_b[5:0], {rpap_pkg::MACRO_PITCH_LOG2{1'b0}}};
          end
        end
      end
      rpap_pkg::ST_ALO: begin
        if (from_mem || rx_valid) begin
          r_next.xaddr[7:0] = in_b;
          r_next.mptr = from_mem ? 10'(r_reg.mptr + 10'h001) : r_reg.mptr;
          r_next.state = rpap_pkg::ST_AHI;
        end
      end
      rpap_pkg::ST_AHI: begin
        if (from_mem || rx_valid) begin
          r_next.xaddr[15:8] = in_b;
          r_next.aptr = {in_b, r_reg.xaddr[7:0]};
          r_next.mptr = from_mem ? 10'(r_reg.mptr + 10'h001) : r_reg.mptr;
          r_next.state = rpap_pkg::ST_XFER;
        end
      end
      rpap_pkg::ST_XFER: begin
        if (!r_reg.hdr[rpap_pkg::HB_WRITE]) begin
          // read byte out, checksum follows later
          r_next.txbyte = mem_rdata;
          r_next.txcrc = rpap_pkg::rpap_crc8(r_reg.txcrc, mem_rdata);
          r_next.sent_any = 1'b1;
          r_next.state = rpap_pkg::ST_TXB;
        end else if (from_mem || rx_valid) begin
          // write data from macro body or stream
          mem_we = 1'b1;
          r_next.mptr = from_mem ? 10'(r_reg.mptr + 10'h001) : r_reg.mptr;
          r_next.state = !last_byte ? rpap_pkg::ST_XFER : r_reg.in_macro ? rpap_pkg::ST_HDR : rpap_pkg::ST_CRCIN;
        end
        if (!r_reg.hdr[rpap_pkg::HB_WRITE] || from_mem || rx_valid) begin
          r_next.xaddr = 16'(r_reg.xaddr + 16'h0001);
          r_next.cnt = 4'(r_reg.cnt - 4'h1);
          if (last_byte && r_reg.hdr[rpap_pkg::HB_POST_INC]) begin
            r_next.aptr = 16'(r_reg.xaddr + 16'h0001);
          end
        end
      end
      rpap_pkg::ST_TXB: begin
        if (tx_ready) begin
          r_next.state = (r_reg.cnt != 4'h0) ? rpap_pkg::ST_XFER :
                         r_reg.in_macro ? rpap_pkg::ST_HDR : rpap_pkg::ST_CRCIN;
        end
      end
      rpap_pkg::ST_CRCIN: begin
        if (rx_valid) begin
          if (rpap_pkg::rpap_crc8(r_reg.rxcrc, rx_data) != 8'h00) begin
            r_next.crc_err = 1'b1;
          end
          r_next.txbyte = r_reg.sent_any ? r_reg.txcrc : rpap_pkg::EMPTY_REPLY_CRC;
          r_next.state = rpap_pkg::ST_TXCRC;
        end
      end
      rpap_pkg::ST_TXCRC: begin
        if (tx_ready) begin
          r_next.state = rpap_pkg::ST_HDR;
          r_next.in_macro = 1'b0;
          r_next.rxcrc = 8'h00;
          r_next.txcrc = 8'h00;
          r_next.sent_any = 1'b0;
        end
      end
      default: begin
        r_next.state = rpap_pkg::ST_HDR;
      end
    endcase
    // idle stream drops a partial command
    if (wait_rx && !rx_valid && r_reg.idle_cnt == r_reg.timeout) begin
      r_next.state = rpap_pkg::ST_HDR;
      r_next.in_macro = 1'b0;
      r_next.rxcrc = 8'h00;
      r_next.txcrc = 8'h00;
      r_next.sent_any = 1'b0;
    end
    // bus slave: one wait state, read data registered
    r_next.ack = bus_take;
    if (bus_take) begin
      case (avs_address)
        rpap_pkg::OFS_CMD: r_next.rdata = 32'h0000_0000;
        rpap_pkg::OFS_FAIL: r_next.rdata = {24'h000000, r_reg.fail};
        rpap_pkg::OFS_DESC: r_next.rdata = {16'h0000, r_reg.desc_ptr};
        rpap_pkg::OFS_STAT: r_next.rdata = {r_reg.aptr, 5'h00, r_reg.crc_err, r_reg.halted, r_reg.in_macro,
                                            5'h00, r_reg.state};
        rpap_pkg::OFS_TMO: r_next.rdata = {16'h0000, r_reg.timeout};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr && avs_address == rpap_pkg::OFS_TMO) begin
      r_next.timeout[7:0] = avs_byteenable[0] ? avs_writedata[7:0] : r_reg.timeout[7:0];
      r_next.timeout[15:8] = avs_byteenable[1] ? avs_writedata[15:8] : r_reg.timeout[15:8];
    end
    if (bus_wr && avs_address == rpap_pkg::OFS_CMD) begin
      if (cmd_val == rpap_pkg::CMD_HALT_ALL) begin
        r_next.halted = 1'b1;
        r_next.state = rpap_pkg::ST_HDR;
        r_next.in_macro = 1'b0;
      end else if (cmd_val[11:8] == rpap_pkg::CMD_SETUP_START) begin
        r_next.halted = 1'b0;
        r_next.state = rpap_pkg::ST_HDR;
        r_next.in_macro = 1'b0;
        r_next.crc_err = 1'b0;
        r_next.aptr = 16'h0000;
        r_next.rxcrc = 8'h00;
        r_next.txcrc = 8'h00;
        r_next.sent_any = 1'b0;
        r_next.fail = cmd_val[7:0] & ~r_reg.lkq;
        r_next.desc_ptr = mem_word;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !r_reg.ack;
  assign avs_readdata = r_reg.rdata;
  assign tx_valid = r_reg.state == rpap_pkg::ST_TXB || r_reg.state == rpap_pkg::ST_TXCRC;
  assign tx_data = r_reg.txbyte;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic hdr_take;
  assign hdr_take = r_reg.state == rpap_pkg::ST_HDR && wait_rx && rx_valid && r_reg.idle_cnt != r_reg.timeout
                    && !bus_wr;

  a_hdr_class_data: assert property (hdr_take && rx_data[7:6] == 2'b01 |=> r_reg.hdr == $past(rx_data))
    else $error("data header not latched");
  a_size_decode: assert property (hdr_take && rx_data[7:6] == 2'b01 |=> r_reg.cnt == (4'h1 << $past(rx_data[1:0])))
    else $error("transfer size wrong");
  a_current_addr: assert property (hdr_take && rx_data[7:6] == 2'b01 && !rx_data[2]
    |=> r_reg.state == rpap_pkg::ST_XFER && r_reg.xaddr == $past(r_reg.aptr))
    else $error("current pointer not used");
  a_macro_entry: assert property (hdr_take && rx_data[7:6] == 2'b10
    |=> r_reg.in_macro && r_reg.mptr == {$past(rx_data[5:0]), 3'b000})
    else $error("macro start address wrong");
  a_read_order: assert property (r_reg.state == rpap_pkg::ST_XFER && !r_reg.hdr[5] && !bus_wr
    |=> r_reg.state == rpap_pkg::ST_TXB && r_reg.xaddr == $past(r_reg.xaddr) + 16'h0001 ##0 tx_valid)
    else $error("read byte order broken");
  a_empty_crc: assert property (r_reg.state == rpap_pkg::ST_TXCRC && !r_reg.sent_any |-> tx_data == 8'h00)
    else $error("empty reply crc not zero");
  a_idle_reset: assert property (wait_rx && !rx_valid && r_reg.idle_cnt == r_reg.timeout
    |=> r_reg.state == rpap_pkg::ST_HDR && !r_reg.in_macro)
    else $error("idle timeout did not reset parser");
  a_ptr_hold: assert property (r_reg.state == rpap_pkg::ST_XFER && !r_reg.hdr[3] && !bus_wr |=> $stable(r_reg.aptr))
    else $error("pointer moved without post increment");
  a_crc_flag: assert property (r_reg.state == rpap_pkg::ST_CRCIN && rx_valid && !bus_wr && r_reg.idle_cnt != 16'hFFFF
    && rpap_pkg::rpap_crc8(r_reg.rxcrc, rx_data) != 8'h00 |=> r_reg.crc_err)
    else $error("bad command crc not flagged");
  a_macro_data: assert property (r_reg.state == rpap_pkg::ST_XFER && r_reg.in_macro && r_reg.hdr[5] && r_reg.hdr[4]
    |-> mem_we && !wait_rx)
    else $error("macro data not taken from body");
  a_start_fail: assert property (bus_wr && avs_address == 5'h00 && avs_writedata[11:8] == 4'hF
    |=> r_reg.fail == ($past(avs_writedata[7:0]) & ~$past(r_reg.lkq)) && !r_reg.halted)
    else $error("start fail mask wrong");

  c_read_reply: cover property (r_reg.state == rpap_pkg::ST_TXCRC && r_reg.sent_any && tx_ready);
  c_macro_run: cover property (r_reg.in_macro && r_reg.state == rpap_pkg::ST_XFER);
  c_crc_error: cover property ($rose(r_reg.crc_err));
  c_timeout: cover property (wait_rx && !rx_valid && r_reg.idle_cnt == r_reg.timeout && r_reg.state != rpap_pkg::ST_HDR);

endmodule

// ---- hdl/rpap_pkg.sv ----
// constants, state type and checksum helper for the remote parameter access parser
package rpap_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CHAR_TIME_NS = 4000;
  localparam int CHAR_CYCLES = CHAR_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_CHARS = 4;
  localparam logic [15:0] TIMEOUT_RST = 16'(TIMEOUT_CHARS * CHAR_CYCLES);

  // ==========================================================
  // register map (byte offsets)
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_FAIL = 5'h04;
  localparam logic [4:0] OFS_DESC = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_TMO = 5'h10;

  // ==========================================================
  // command register codes
  localparam logic [11:0] CMD_HALT_ALL = 12'h800;
  localparam logic [3:0] CMD_SETUP_START = 4'hF;

  // ==========================================================
  // header layout
  localparam logic [1:0] CLASS_DATA = 2'b01;
  localparam logic [1:0] CLASS_MACRO = 2'b10;
  localparam int HB_WRITE = 5;
  localparam int HB_FROM_MACRO = 4;
  localparam int HB_POST_INC = 3;
  localparam int HB_ADDR_FIELD = 2;

  // ==========================================================
  // remote memory
  localparam int MEM_BYTES = 1024;
  localparam int MEM_AW = 10;
  localparam int MACRO_PITCH_LOG2 = 3;
  localparam logic [9:0] DESC_PTR_LOC = 10'h3FE;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam logic [7:0] EMPTY_REPLY_CRC = 8'h00;

  typedef enum logic [2:0] {
    ST_HDR,
    ST_ALO,
    ST_AHI,
    ST_XFER,
    ST_TXB,
    ST_CRCIN,
    ST_TXCRC
  } rpap_state_t;

  // one byte into a reflected crc-8 (x^8+x^5+x^4+1)
  function automatic logic [7:0] rpap_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ---- hdl/rpap_ram.sv ----
// byte memory of the remote: macro table, parameters and descriptors
`timescale 1ns/1ps
module rpap_ram (
  // clock
  input wire logic mclk,
  // write port
  input wire logic we,
  input wire logic [9:0] waddr,
  input wire logic [7:0] wdata,
  // byte read port
  input wire logic [9:0] raddr,
  output logic [7:0] rdata,
  // word read port, little endian
  input wire logic [9:0] waddr_word,
  output logic [15:0] rword
);

  logic [7:0] mem [0:rpap_pkg::MEM_BYTES-1];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
  assign rword = {mem[10'(waddr_word + 10'h001)], mem[waddr_word]};

endmodule

// ---- test/rpap_host_model.sv ----
// host end of the serial stream: sends command bytes, sinks reply bytes
`timescale 1ns/1ps
module rpap_host_model (
  // clock
  input wire logic mclk,
  // stream toward the parser
  output logic rx_valid,
  output logic [7:0] rx_data,
  // stream back from the parser
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  logic slow = 1'b0;
  logic [7:0] crc_acc = 8'h00;
  logic [7:0] got_q[$];

  // ==========================================================
  // checksum
  // reflected crc-8, x^8+x^5+x^4+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 8'h8C) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================
  // reply sink, stalls at random when slow
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  always @(posedge mclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got_q.push_back(tx_data);
    end
    tx_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
  end

  // ==========================================================
  // one byte per pulse; data line flips once released
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    crc_acc = crc8(crc_acc, b);
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask

  // command closes with its crc byte
  task automatic send_crc();
    send(crc_acc);
    crc_acc = 8'h00;
  endtask
endmodule

// ---- test/test_remote_param_access_protocol.sv ----
// self-checking bench for the remote parameter access parser
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_remote_param_access_protocol;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] chan_link_ok;
  logic rx_valid;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] mem [0:1023];
  int ptr = 0;
  logic [31:0] rd;
  logic [15:0] adr;
  logic [15:0] desc;
  logic [7:0] mask;
  logic [63:0] wd;

  rpap_parser dut_u (.mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_link_ok(chan_link_ok),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  rpap_host_model host_u (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // closing report
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // register bus: hold until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic wr, input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_byteenable <= be;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      close_out();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // let one edge pass before the next request rises
    @(posedge mclk);
  endtask

  // ==========================================================
  // stream helpers and reference model
  task automatic take(input logic [7:0] e, input string nm);
    int n;
    n = 0;
    while (host_u.got_q.size() == 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      close_out();
    end
    `CHK(nm, e, host_u.got_q.pop_front())
  endtask

  task automatic do_cmd(input logic [7:0] h, input logic [15:0] a, input logic [63:0] d);
    int n;
    int p;
    logic [7:0] c;
    n = 1 << h[1:0];
    p = h[2] ? int'(a) : ptr;
    c = 8'h00;
    host_u.send(h);
    if (h[2]) begin
      host_u.send(a[7:0]);
      host_u.send(a[15:8]);
    end
    for (int k = 0; k < n; k++) begin
      if (h[5]) begin
        host_u.send(d[8*k +: 8]);
        mem[(p + k) % 1024] = d[8*k +: 8];
      end else begin
        take(mem[(p + k) % 1024], "read byte");
        c = host_u.crc8(c, mem[(p + k) % 1024]);
      end
    end
    ptr = h[3] ? (p + n) % 65536 : p;
    host_u.send_crc();
    take(c, "reply crc");
  endtask

  task automatic check_stat(input logic [1:0] err_halt);
    bus(5'h0C, 1'b0, 4'hF, 32'h0, rd);
    `CHK("pointer", ptr[15:0], rd[31:16])
    `CHK("error and halt", err_halt, rd[10:9])
    `CHK("parser state", 3'h0, rd[2:0])
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(73369));
    avs_address <= 5'h00;
    avs_byteenable <= 4'hF;
    avs_writedata <= 32'h0;
    chan_link_ok <= 8'hFF;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chan_link_ok <= 8'($urandom());
    bus(5'h14, 1'b1, 4'hF, 32'hFFFF_FFFF, rd);
    for (int i = 0; i < 6; i++) begin
      bus(5'(4 * i), 1'b0, 4'hF, 32'h0, rd);
      `CHK("reset value", (i == 4) ? 32'h0000_07D0 : 32'h0, rd)
    end
    desc = 16'($urandom_range(16'hFFFF, 16'h0001));
    do_cmd(8'h65, 16'h03FE, {48'h0, desc});
    bus(5'h00, 1'b1, 4'hF, 32'h0000_0800, rd);
    host_u.send(8'h47);
    host_u.crc_acc = 8'h00;
    repeat (20) @(posedge mclk);
    `CHK("halted reply", 0, host_u.got_q.size())
    check_stat(2'b01);
    mask = 8'($urandom());
    bus(5'h00, 1'b1, 4'hF, {20'h0, 4'hF, mask}, rd);
    ptr = 0;
    bus(5'h00, 1'b0, 4'hF, 32'h0, rd);
    `CHK("command clear", 32'h0, rd)
    bus(5'h04, 1'b0, 4'hF, 32'h0, rd);
    `CHK("start failures", {24'h0, mask & ~chan_link_ok}, rd)
    bus(5'h08, 1'b0, 4'hF, 32'h0, rd);
    `CHK("table pointer", {16'h0, desc}, rd)
    check_stat(2'b00);
    for (int pass = 0; pass < 2; pass++) begin
      host_u.slow = pass[0];
      for (int sz = 0; sz < 4; sz++) begin
        adr = 16'($urandom_range(16'h03F0, 16'h0200));
        wd = {$urandom(), $urandom()};
        do_cmd(8'h64 | 8'(sz), adr, wd);
        do_cmd(8'h44 | 8'(sz), adr, 64'h0);
        check_stat(2'b00);
      end
    end
    do_cmd(8'h6E, 16'h0010, 64'h0000_0000_DDCC_BBAA);
    check_stat(2'b00);
    do_cmd(8'h61, 16'h0000, 64'h0000_0000_0000_FFEE);
    do_cmd(8'h65, 16'h0016, 64'h0000_0000_0000_7733);
    do_cmd(8'h47, 16'h0010, 64'h0);
    do_cmd(8'h40, 16'h0000, 64'h0);
    check_stat(2'b00);
    do_cmd(8'h66, 16'h01F8, 64'h0000_0000_0000_1245);
    host_u.send(8'hBF);
    take(mem[18], "macro byte");
    take(mem[19], "macro byte");
    repeat (4) @(posedge mclk);
    host_u.send_crc();
    take(host_u.crc8(host_u.crc8(8'h00, mem[18]), mem[19]), "macro crc");
    ptr = 16'h0012;
    check_stat(2'b00);
    host_u.send(8'h64);
    host_u.send(8'h00);
    host_u.send(8'h03);
    host_u.send(8'h5A);
    mem[768] = 8'h5A;
    host_u.send(host_u.crc_acc ^ 8'h01);
    host_u.crc_acc = 8'h00;
    take(8'h00, "reply crc");
    ptr = 16'h0300;
    check_stat(2'b10);
    bus(5'h10, 1'b1, 4'h3, 32'hFFFF_0014, rd);
    bus(5'h10, 1'b0, 4'hF, 32'h0, rd);
    `CHK("timeout", 32'h0000_0014, rd)
    host_u.send(8'h64);
    host_u.send(8'h20);
    host_u.crc_acc = 8'h00;
    repeat (40) @(posedge mclk);
    bus(5'h0C, 1'b0, 4'hF, 32'h0, rd);
    `CHK("idle state", 3'h0, rd[2:0])
    do_cmd(8'h44, 16'h0300, 64'h0);
    chan_link_ok <= 8'($urandom());
    repeat (4) @(posedge mclk);
    mask = 8'($urandom());
    bus(5'h00, 1'b1, 4'hF, {20'h0, 4'hF, mask}, rd);
    ptr = 0;
    bus(5'h04, 1'b0, 4'hF, 32'h0, rd);
    `CHK("restart failures", {24'h0, mask & ~chan_link_ok}, rd)
    check_stat(2'b00);
    close_out();
  end
endmodule
